// [hdl/adc_chain_regs.vh]
`ifndef ADC_CHAIN_REGS_VH
`define ADC_CHAIN_REGS_VH

// Result width in bits.
`define ADC_RESULT_BITS 16
// Conversion time in nanoseconds.
`define ADC_CONV_TIME_NS 1000
// Clock period of clk_i in nanoseconds.
`define ADC_CLK_PERIOD_NS 10
// Conversion time in clk_i cycles, rounded up.
`define ADC_CONV_CYCLES ((`ADC_CONV_TIME_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)

`endif

// [hdl/adc_sync_edge.v]
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser with rise and fall detection on the settled level.
module adc_sync_edge (
  // Clock and reset.
  input wire clk_i,
  input wire reset_i,
  // Asynchronous level in.
  input wire async_i,
  // Synchronised level and edge pulses.
  output wire level_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  // First flop feeds only the second; edges come from the settled pair.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // Edge pulses last one clk_i cycle.
  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~last_reg;
  assign fall_o = ~sync_reg & last_reg;

endmodule

`default_nettype wire

// [hdl/adc_chain_port.v]
// Summary of operation
// RULE1: Each convert_start rise latches the mode from SDI, high for chip-select and low for chain.
// RULE2: With SDI and convert_start both low the output is driven low, not floated.
// RULE3: A convert_start rise with SCK low starts a conversion in chain mode without busy flag.
// RULE4: A convert_start rise with SCK high starts a conversion in chain mode with busy flag.
// RULE5: The host keeps convert_start high through conversion and readback.
// RULE6: Without busy flag the result MSB appears on SDO at end of conversion.
// RULE7: Remaining result bits move onto SDO on each later SCK falling edge.
// RULE8: Each SCK falling edge shifts the SDI level into the shift register; here the fall that ends the busy flag shifts nothing.
// RULE9: Without busy flag the host gives 16 clocks per converter, MSB first.
// RULE10: With busy flag the host gives 16 per converter plus one clock.
// RULE11: SDO stays stable across both SCK edges, changing only after a fall.
// RULE12: With busy flag the device drives SDO high once the chain has finished; here SDO goes high when this converter's own conversion ends.
// RULE13: After the busy flag, stored bits shift out MSB first on SCK falls.
// RULE14: The host holds SCK still during conversion.
// RULE15: End of conversion loads the full result, replacing old contents.
`timescale 1ns/1ns
`default_nettype none
`include "adc_chain_regs.vh"

module adc_chain_port #(
  parameter WIDTH = `ADC_RESULT_BITS,
  parameter CONV_CYCLES = `ADC_CONV_CYCLES
) (
  // Clock and reset.
  input wire clk_i,
  input wire reset_i,
  // Link pins from the host and upstream converter.
  input wire convert_start_i,
  input wire sck_i,
  input wire sdi_i,
  // Serial data out; oe_n low means the pin is driven.
  output reg sdo_o,
  output reg sdo_oe_n_o,
  // Sample from the analog core, taken at end of conversion.
  input wire [WIDTH-1:0] sample_i,
  // Status.
  output reg chain_mode_o,
  output reg busy_mode_o,
  output reg converting_o
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_CONV = 4'h2;
  localparam [3:0] ST_READ = 4'h4;
  localparam [3:0] ST_CSM = 4'h8;

  wire cnv_lvl;
  wire cnv_rise;
  wire sck_lvl;
  wire sck_fall;
  wire sdi_lvl;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [WIDTH-1:0] shift_reg;
  reg [WIDTH-1:0] shift_next;
  reg [15:0] count_reg;
  reg [15:0] count_next;
  reg lead_reg;
  reg lead_next;
  reg sdo_next;
  reg chain_next;
  reg busy_next;
  reg sdi_hold_reg;

  // Last conversion cycle; the counter runs from zero up to this value.
  localparam [31:0] CONV_LAST = CONV_CYCLES - 1;

  // Decides whether the pin is driven for a given next state and levels.
  // Idle drives low only with SDI and start both low, so a chip-select
  // neighbour sharing the line is never fought.
  function pin_driven;
    input [3:0] state;
    input sdi_low;
    input cnv_low;
    begin
      pin_driven = (state == ST_CONV) || (state == ST_READ) ||
                   ((state == ST_IDLE) && sdi_low && cnv_low);
    end
  endfunction

  // Synchronised convert_start with edge detection.
  adc_sync_edge u_cnv (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(convert_start_i),
    .level_o(cnv_lvl),
    .rise_o(cnv_rise),
    .fall_o()
  );

  // Synchronised serial clock with edge detection.
  adc_sync_edge u_sck (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(sck_i),
    .level_o(sck_lvl),
    .rise_o(),
    .fall_o(sck_fall)
  );

  // Synchronised serial data in.
  adc_sync_edge u_sdi (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(sdi_i),
    .level_o(sdi_lvl),
    .rise_o(),
    .fall_o()
  );

  // SDI as it stood one clock earlier. A detected SCK fall is two flops
  // late, so this is the level from just before the pin edge, the one an
  // upstream converter still holds; the chain needs no hold time from it.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sdi_hold_reg <= 1'b0;
    end else begin
      sdi_hold_reg <= sdi_lvl;
    end
  end

  // Next-state logic for the conversion and readback sequence.
  // A start rise always wins over the running sequence, so a host that
  // drops and raises the start line mid-readback begins a fresh sample.
  // SCK falls are ignored outside readback, which keeps a free-running
  // host clock from disturbing the result during conversion.
  always @* begin
    state_next = state_reg;
    shift_next = shift_reg;
    count_next = count_reg;
    lead_next = lead_reg;
    sdo_next = sdo_o;
    chain_next = chain_mode_o;
    busy_next = busy_mode_o;
    if (cnv_rise) begin
      chain_next = ~sdi_lvl; // RULE1
      busy_next = ~sdi_lvl & sck_lvl; // RULE3 RULE4
      count_next = 16'h0000;
      state_next = sdi_lvl ? ST_CSM : ST_CONV;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (!sdi_lvl && !cnv_lvl) begin
            sdo_next = 1'b0; // RULE2
          end
        end
        ST_CONV: begin
          if (count_reg == CONV_LAST[15:0]) begin
            shift_next = sample_i; // RULE15
            state_next = ST_READ;
            if (busy_mode_o) begin
              sdo_next = 1'b1; // RULE12
              lead_next = 1'b1;
            end else begin
              sdo_next = sample_i[WIDTH-1]; // RULE6
              lead_next = 1'b0;
            end
          end else begin
            count_next = count_reg + 16'h0001;
          end
        end
        ST_READ: begin
          if (!cnv_lvl) begin
            state_next = ST_IDLE;
          end else if (sck_fall) begin
            // Data only changes after a fall, stable across the rise.
            if (lead_reg) begin
              lead_next = 1'b0;
              sdo_next = shift_reg[WIDTH-1]; // RULE13
            end else begin
              shift_next = {shift_reg[WIDTH-2:0], sdi_hold_reg}; // RULE8
              sdo_next = shift_reg[WIDTH-2]; // RULE7 RULE11
            end
          end
        end
        ST_CSM: begin
          // Chip-select readback lives elsewhere; go idle once start drops.
          if (!cnv_lvl) begin
            state_next = ST_IDLE;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // State registers.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      shift_reg <= {WIDTH{1'b0}};
      count_reg <= 16'h0000;
      lead_reg <= 1'b0;
      sdo_o <= 1'b0;
      chain_mode_o <= 1'b0;
      busy_mode_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      count_reg <= count_next;
      lead_reg <= lead_next;
      sdo_o <= sdo_next;
      chain_mode_o <= chain_next;
      busy_mode_o <= busy_next;
    end
  end

  // Output enable and status flags, registered.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sdo_oe_n_o <= 1'b1;
      converting_o <= 1'b0;
    end else begin
      sdo_oe_n_o <= ~pin_driven(state_next, ~sdi_lvl, ~cnv_lvl); // RULE2
      converting_o <= (state_next == ST_CONV);
    end
  end

endmodule

`default_nettype wire

// [tb/adc_chain_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module adc_chain_checker (
  // Clock, reset and pins.
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic convert_start_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  input wire logic chain_mode_o,
  input wire logic busy_mode_o,
  input wire logic converting_o
);
  // Short aliases keep each check but p_hold and p_oe on one line.
  wire logic st = convert_start_i;
  wire logic cv = converting_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_idle; (!st && !sdi_i)[*5] |-> !sdo_o && !sdo_oe_n_o; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_nb; $rose(cv) && !sck_i |-> chain_mode_o && !busy_mode_o; endproperty
  a_nb: assert property (p_nb) else $error("nobusy");
  property p_bz; $rose(cv) && sck_i |-> chain_mode_o && busy_mode_o; endproperty
  a_bz: assert property (p_bz) else $error("busy");
  property p_go; $rose(cv) |-> $past(st, 2); endproperty
  a_go: assert property (p_go) else $error("go");
  property p_cv; $rose(st) |-> ##[1:6] cv; endproperty
  a_cv: assert property (p_cv) else $error("conv");
  property p_hi; $fell(cv) && busy_mode_o |-> ##[0:1] sdo_o; endproperty
  a_hi: assert property (p_hi) else $error("done");
  property p_hold; sck_i && $past(sck_i) && st && $past(st, 5) && !cv
    && !$past(cv) && !$past(cv, 2) |-> $stable(sdo_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_oe; st && $past(st, 6) && chain_mode_o && !cv |-> !sdo_oe_n_o;
  endproperty
  a_oe: assert property (p_oe) else $error("drive");
  cover property ($fell(cv) && busy_mode_o);
  cover property ($fell(sck_i) && chain_mode_o);
  cover property ($fell(st) && chain_mode_o);
endmodule
bind adc_chain_port adc_chain_checker u_chk (.*);
`default_nettype wire

// [tb/adc_up_model.sv]
`timescale 1ns/1ns
`default_nettype none
module adc_up_model (
  input wire logic cnv_i,
  input wire logic sck_i,
  input wire logic [15:0] word_i,
  output logic sdi_o
);
  logic rdy = 1'b0;
  logic [15:0] sr = 16'h0000;
  // Result shows only once this converter has finished.
  always @(posedge cnv_i) begin
    rdy = 1'b0;
    sr = word_i;
    #60 rdy = cnv_i;
  end
  // Each fall moves the next bit out, zeros behind it.
  always @(negedge sck_i) begin
    if (rdy) sr = {sr[14:0], 1'b0};
  end
  // Idle output is driven low, not floated.
  assign sdi_o = cnv_i & rdy & sr[15];
endmodule
`default_nettype wire

// [tb/adc_daisy_chain_readout_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module adc_daisy_chain_readout_tb_top;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic convert_start_i = 1'b0;
  logic sck_i = 1'b0;
  logic [15:0] sample_i = 16'h0000;
  logic [15:0] up = 16'h0000;
  logic sdi_i, sdo_o, sdo_oe_n_o, chain_mode_o, busy_mode_o, converting_o;
  logic [32:0] v;
  logic [31:0] r = 32'h00015d49;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  // System clock.
  always #5 clk_i = ~clk_i;
  adc_chain_port #(.CONV_CYCLES(4)) dut (.*);
  adc_up_model up_m (.cnv_i(convert_start_i), .sck_i(sck_i), .word_i(up),
    .sdi_o(sdi_i));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end
  // Readbacks with and without the busy flag, corner words first.
  initial begin
    tk(10);
    reset_i <= 1'b0;
    tk(4);
    for (int k = 0; k < 6; k++) begin
      r = lfsr(lfsr(r));
      sample_i <= (k < 2) ? {16{k[0]}} : r[15:0];
      up <= r[31:16];
      sck_i <= k[0];
      tk(2);
      convert_start_i <= 1'b1;
      while (converting_o !== 1'b1) tk(1);
      while (converting_o !== 1'b0) tk(1);
      tk(6);
      v = k[0] ? {1'b1, sample_i, 16'h0000} : {sample_i, up, 1'b0};
      chk("chain", 1'b1, chain_mode_o);
      chk("busy", k[0], busy_mode_o);
      for (int i = 0; i < (k[0] ? 17 : 32); i++) begin
        sck_i <= 1'b1;
        tk(4);
        chk("sdo", v[32 - i], sdo_o);
        sck_i <= 1'b0;
        tk(4);
      end
      convert_start_i <= 1'b0;
      tk(8);
      chk("oe_n", 1'b0, sdo_oe_n_o);
      chk("idle", 1'b0, sdo_o);
    end
    complete_run;
  end
endmodule
`default_nettype wire
